// ===== core/rw_buffer_pkg.sv
// constants and types shared by the buffered read/write transceiver
package rw_buffer_pkg;
    // ****************************************
    // data path geometry
    // ****************************************
    localparam int DATA_W = 18;
    localparam int DEPTH = 4;
    localparam int PTR_W = 3;
    localparam int MON_DEPTH = 2;
    localparam logic [DATA_W-1:0] QUEUE_OUT_RESET = 18'h3ffff;
    localparam logic [PTR_W-1:0] QUEUE_FULL_COUNT = 3'h4;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [3:0] MON_ADDR = 4'h8;
    localparam int CTRL_FLUSH_BIT = 0;
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_FULL_N_BIT = 3;
    localparam int STAT_EMPTY_BIT = 4;
    localparam int STAT_MON_LSB = 5;
    localparam int MON_VALID_BIT = 31;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    // pin samples, one word per synchroniser stage
    typedef struct packed {
        logic [DATA_W-1:0] a;
        logic [DATA_W-1:0] b;
        logic wr_n;
        logic rd_n;
        logic rst_n;
        logic b_oe_n;
        logic a_oe_n;
        logic open;
    } pin_t;
endpackage : rw_buffer_pkg

// ===== core/buffered_rw_bus_transceiver.sv
// buffered read/write transceiver: four-word write queue, read latch, ahb-lite status port
`timescale 1ns/1ps

module buffered_rw_bus_transceiver
    import rw_buffer_pkg::*;
(
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // ahb slave select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size, word only
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // ahb ready out
    output logic [1:0] hresp, // ahb response
    output logic [31:0] hrdata, // ahb read data
    input wire logic [rw_buffer_pkg::DATA_W-1:0] host_side_bus_in, // host bus level
    output logic [rw_buffer_pkg::DATA_W-1:0] host_side_bus_out, // latch word to host bus
    output logic host_side_bus_oe, // high while driving host bus
    input wire logic [rw_buffer_pkg::DATA_W-1:0] memory_side_bus_in, // memory bus level
    output logic [rw_buffer_pkg::DATA_W-1:0] memory_side_bus_out, // queue word to memory bus
    output logic memory_side_bus_oe, // high while driving memory bus
    input wire logic queue_write_enable_n, // push when low
    input wire logic queue_read_enable_n, // pop when low
    input wire logic queue_reset_n, // synchronous queue reset
    input wire logic b_side_drive_enable_n, // memory bus drive enable
    input wire logic a_side_drive_enable_n, // host bus drive enable
    input wire logic read_latch_open, // read latch transparent when high
    output logic queue_full_n, // low while four words stored
    output logic mon_ready // pop log has room
);
    import rw_buffer_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        pin_t s1;
        pin_t s2;
        logic [DEPTH-1:0][DATA_W-1:0] mem;
        logic [PTR_W-1:0] wptr;
        logic [PTR_W-1:0] rptr;
        logic [DATA_W-1:0] qout;
        logic full_n;
        logic [DATA_W-1:0] latch;
        logic a_oe;
        logic b_oe;
        logic [MON_DEPTH-1:0][DATA_W-1:0] mon;
        logic mon_head;
        logic [1:0] mon_cnt;
        logic mon_ready;
        logic wr_pend;
        logic [3:0] wr_addr;
        logic flush;
        logic [31:0] rdata;
    } state_t;

    // synchronisers rest at the pins' idle levels, so no active-low enable looks asserted after reset
    localparam pin_t PIN_IDLE = '{
        a: '0, b: '0, wr_n: 1'b1, rd_n: 1'b1, rst_n: 1'b1,
        b_oe_n: 1'b1, a_oe_n: 1'b1, open: 1'b0
    };

    localparam state_t STATE_RESET = '{
        s1: PIN_IDLE, s2: PIN_IDLE, mem: '0, wptr: '0, rptr: '0,
        qout: QUEUE_OUT_RESET, full_n: 1'b1, latch: '0,
        a_oe: 1'b0, b_oe: 1'b0, mon: '0, mon_head: 1'b0,
        mon_cnt: 2'h0, mon_ready: 1'b1, wr_pend: 1'b0,
        wr_addr: 4'h0, flush: 1'b0, rdata: 32'h0
    };

    state_t st;
    state_t next_st;
    pin_t p;
    logic [PTR_W-1:0] count;
    logic empty;
    logic full;
    logic do_wr;
    logic do_rd;
    logic qrst;
    logic addr_ok;
    logic mon_pop;
    logic mon_push;
    logic [PTR_W-1:0] next_count;

    // settled pin view, two stages behind the pins
    assign p = st.s2;
    assign count = st.wptr - st.rptr;
    assign empty = (count == '0);
    assign full = (count == QUEUE_FULL_COUNT);
    assign qrst = !p.rst_n || st.flush;
    // full takes the read and drops the write, empty the reverse
    assign do_wr = !p.wr_n && !full && !qrst;
    assign do_rd = !p.rd_n && !empty && !qrst;
    assign addr_ok = hsel && htrans[1] && hready;
    assign mon_pop = addr_ok && !hwrite && (haddr[3:0] == MON_ADDR) && (st.mon_cnt != 2'h0);
    // a pop while the log is full is simply not logged; mon_ready shows it
    assign mon_push = do_rd && st.mon_ready;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_st = st;
        next_count = '0;
        // two flip-flops on every pin before use
        next_st.s1 = '{a: host_side_bus_in, b: memory_side_bus_in,
                       wr_n: queue_write_enable_n, rd_n: queue_read_enable_n,
                       rst_n: queue_reset_n, b_oe_n: b_side_drive_enable_n,
                       a_oe_n: a_side_drive_enable_n, open: read_latch_open};
        next_st.s2 = st.s1;

        // write queue, touched only by its own enables, its reset pin and the control-register flush
        if (qrst) begin
            next_st.wptr = '0;
            next_st.rptr = '0;
            next_st.qout = QUEUE_OUT_RESET;
            next_st.full_n = 1'b1;
        end else begin
            if (do_wr) begin
                next_st.mem[st.wptr[1:0]] = p.a;
                next_st.wptr = st.wptr + 3'h1;
            end
            if (do_rd) begin
                next_st.qout = st.mem[st.rptr[1:0]];
                next_st.rptr = st.rptr + 3'h1;
            end
            next_count = next_st.wptr - next_st.rptr;
            next_st.full_n = (next_count != QUEUE_FULL_COUNT);
        end

        // read latch follows the memory bus only while open
        if (p.open) begin
            next_st.latch = p.b;
        end
        next_st.a_oe = !p.a_oe_n;
        next_st.b_oe = !p.b_oe_n;

        // pop log, two entries
        if (mon_push) begin
            next_st.mon[st.mon_head ^ st.mon_cnt[0]] = st.mem[st.rptr[1:0]];
        end
        if (mon_pop) begin
            next_st.mon_head = !st.mon_head;
        end
        next_st.mon_cnt = st.mon_cnt + {1'b0, mon_push} - {1'b0, mon_pop};
        next_st.mon_ready = (next_st.mon_cnt != 2'h2);

        // ahb: read data is prepared in the address phase
        next_st.flush = 1'b0;
        if (st.wr_pend && (st.wr_addr == CTRL_ADDR)) begin
            next_st.flush = hwdata[CTRL_FLUSH_BIT];
        end
        next_st.wr_pend = addr_ok && hwrite;
        next_st.wr_addr = haddr[3:0];
        if (addr_ok && !hwrite) begin
            unique case (haddr[3:0])
                STATUS_ADDR: begin
                    next_st.rdata = 32'h0;
                    next_st.rdata[STAT_COUNT_LSB +: PTR_W] = count;
                    next_st.rdata[STAT_FULL_N_BIT] = st.full_n;
                    next_st.rdata[STAT_EMPTY_BIT] = empty;
                    next_st.rdata[STAT_MON_LSB +: 2] = st.mon_cnt;
                end
                MON_ADDR: begin
                    next_st.rdata = 32'h0;
                    next_st.rdata[DATA_W-1:0] = st.mon[st.mon_head];
                    next_st.rdata[MON_VALID_BIT] = (st.mon_cnt != 2'h0);
                end
                default: begin
                    next_st.rdata = 32'h0; // control and unmapped read zero
                end
            endcase
        end
    end

    // ****************************************
    // the only register process
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state, except the constant hreadyout and hresp
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = st.rdata;
    assign host_side_bus_out = st.latch;
    assign host_side_bus_oe = st.a_oe;
    assign memory_side_bus_out = st.qout;
    assign memory_side_bus_oe = st.b_oe;
    assign queue_full_n = st.full_n;
    assign mon_ready = st.mon_ready;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_count_bound;
        count <= QUEUE_FULL_COUNT;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("queue holds more than four");

    property p_full_flag;
        ##1 (queue_full_n == (count != QUEUE_FULL_COUNT));
    endproperty
    a_full_flag: assert property (p_full_flag) else $error("full flag disagrees with count");

    property p_full_write_ignored;
        (full && !p.wr_n && p.rd_n && !qrst) |=> ($stable(st.wptr) && $stable(st.mem));
    endproperty
    a_full_write_ignored: assert property (p_full_write_ignored) else $error("write to full queue");

    property p_empty_read;
        (empty && !p.rd_n && p.wr_n && !qrst) |=> ($stable(st.qout) && $stable(st.rptr));
    endproperty
    a_empty_read: assert property (p_empty_read) else $error("read of empty queue acted");

    property p_reset;
        !p.rst_n |=> (count == '0 && memory_side_bus_out == QUEUE_OUT_RESET && queue_full_n);
    endproperty
    a_reset: assert property (p_reset) else $error("queue reset incomplete");

    property p_empty_both;
        (empty && !p.wr_n && !p.rd_n && !qrst) |=> (count == 3'h1 && $stable(st.qout));
    endproperty
    a_empty_both: assert property (p_empty_both) else $error("empty push and pop wrong");

    property p_full_both;
        (full && !p.wr_n && !p.rd_n && !qrst) |=> (count == 3'h3 && st.rptr == $past(st.rptr) + 3'h1);
    endproperty
    a_full_both: assert property (p_full_both) else $error("full push and pop wrong");

    property p_order;
        do_rd |=> (memory_side_bus_out == $past(st.mem[st.rptr[1:0]]));
    endproperty
    a_order: assert property (p_order) else $error("wrong word popped");

    property p_latch;
        p.open |=> (host_side_bus_out == $past(p.b));
    endproperty
    a_latch: assert property (p_latch) else $error("latch not transparent");

    property p_latch_hold;
        !p.open |=> $stable(host_side_bus_out);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("closed latch changed");

    property p_b_drive;
        ##1 (memory_side_bus_oe == !$past(p.b_oe_n));
    endproperty
    a_b_drive: assert property (p_b_drive) else $error("memory side drive wrong");

    property p_a_drive;
        ##1 (host_side_bus_oe == !$past(p.a_oe_n));
    endproperty
    a_a_drive: assert property (p_a_drive) else $error("host side drive wrong");

    property p_sample;
        ##2 (st.s2.a == $past(host_side_bus_in, 2));
    endproperty
    a_sample: assert property (p_sample) else $error("pin sampling delay wrong");

    property p_reset_quiet;
        $rose(hresetn) |-> ##1 (!memory_side_bus_oe && !host_side_bus_oe && queue_full_n)
            ##1 (!memory_side_bus_oe && !host_side_bus_oe && queue_full_n);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("bus driven after reset");

    property p_write_step;
        do_wr |=> (st.wptr == $past(st.wptr) + 3'h1);
    endproperty
    a_write_step: assert property (p_write_step) else $error("write pointer did not step");

    property p_write_store;
        do_wr |=> (st.mem[$past(st.wptr[1:0])] == $past(p.a));
    endproperty
    a_write_store: assert property (p_write_store) else $error("pushed word not stored");

    property p_read_step;
        do_rd |=> (st.rptr == $past(st.rptr) + 3'h1);
    endproperty
    a_read_step: assert property (p_read_step) else $error("read pointer did not step");

    property p_both_middle;
        (!empty && !full && !p.wr_n && !p.rd_n && !qrst)
            |=> ($stable(count) && st.rptr == $past(st.rptr) + 3'h1);
    endproperty
    a_both_middle: assert property (p_both_middle) else $error("push and pop not both done");

    property p_idle_queue;
        (p.wr_n && p.rd_n && !qrst) |=> ($stable(st.wptr) && $stable(st.rptr) && $stable(memory_side_bus_out));
    endproperty
    a_idle_queue: assert property (p_idle_queue) else $error("idle queue moved");

    property p_flush;
        st.flush |=> (count == '0 && memory_side_bus_out == QUEUE_OUT_RESET && queue_full_n);
    endproperty
    a_flush: assert property (p_flush) else $error("flush incomplete");

    property p_mon_word;
        (mon_push && !mon_pop && st.mon_cnt == 2'h0) |=> (st.mon[st.mon_head] == memory_side_bus_out);
    endproperty
    a_mon_word: assert property (p_mon_word) else $error("pop log word wrong");

    property p_flag_stable;
        (!do_wr && !do_rd && !qrst) |=> $stable(queue_full_n);
    endproperty
    a_flag_stable: assert property (p_flag_stable) else $error("full flag moved while idle");

    property p_full_hold;
        (full && !p.wr_n && p.rd_n && !qrst) |=> !queue_full_n;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full flag lost on refused write");

    property p_qout_hold;
        (!do_rd && !qrst) |=> $stable(memory_side_bus_out);
    endproperty
    a_qout_hold: assert property (p_qout_hold) else $error("queue output moved without read");

endmodule : buffered_rw_bus_transceiver

// ===== verification/memory_bus_model.sv
// model of the memory-side bus partner: drives the bus on request, never leaves a stale level
`timescale 1ns/1ps
module memory_bus_model
    import rw_buffer_pkg::*;
(
    input wire logic hclk, // clock
    input wire logic dut_oe, // block drives the bus
    input wire logic [rw_buffer_pkg::DATA_W-1:0] dut_word, // block word
    input wire logic drv_en, // model drives the bus
    input wire logic [rw_buffer_pkg::DATA_W-1:0] drv_word, // model word
    output logic [rw_buffer_pkg::DATA_W-1:0] level // resolved bus level
);
    logic [DATA_W-1:0] last = '0;
    // remember the level so a floating bus can show its inverse
    always @(posedge hclk) begin
        last <= level;
    end
    // a floating bus flips every cycle, so stale data never passes for a held word
    assign level = dut_oe ? dut_word : (drv_en ? drv_word : ~last);
endmodule : memory_bus_model

// ===== verification/buffered_rw_bus_transceiver_tb.sv
// self-checking bench for the buffered read/write transceiver
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module buffered_rw_bus_transceiver_tb;
    import rw_buffer_pkg::*;
    typedef struct {int due; int kind; logic [DATA_W-1:0] exp;} note_t;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, sx, r1;
    logic [1:0] htrans = '0, hresp;
    logic [DATA_W-1:0] host_drv = '0, mem_word = '0, host_lvl, mem_lvl, host_out, mem_out;
    logic [DATA_W-1:0] cur = QUEUE_OUT_RESET, w1;
    logic wr_n = 1, rd_n = 1, qrst_n = 1, b_oe_n = 1, a_oe_n = 1, latch_open = 0, mem_drv = 0;
    logic host_oe, mem_oe, full_n, mon_ready;
    int bad_count = 0, tests_run = 0, mcyc = 0, ticks = 0, seed = 35;
    logic [DATA_W-1:0] fq[$], mq[$];
    note_t notes[$];
    string nm[5] = '{"mem_out", "full_n", "host_out", "host_oe", "mem_oe"};
    always #12.5 hclk = ~hclk;
    assign hready = hreadyout;
    // host bus level: block output when it drives, bench data otherwise
    assign host_lvl = host_oe ? host_out : host_drv;
    buffered_rw_bus_transceiver dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .host_side_bus_in(host_lvl),
        .host_side_bus_out(host_out), .host_side_bus_oe(host_oe), .memory_side_bus_in(mem_lvl),
        .memory_side_bus_out(mem_out), .memory_side_bus_oe(mem_oe), .queue_write_enable_n(wr_n),
        .queue_read_enable_n(rd_n), .queue_reset_n(qrst_n), .b_side_drive_enable_n(b_oe_n),
        .a_side_drive_enable_n(a_oe_n), .read_latch_open(latch_open), .queue_full_n(full_n),
        .mon_ready(mon_ready));
    memory_bus_model partner (.hclk(hclk), .dut_oe(mem_oe), .dut_word(mem_out), .drv_en(mem_drv),
        .drv_word(mem_word), .level(mem_lvl));
    // ****************************************
    // notes, checking and closing
    // ****************************************
    task automatic note(input int k, input logic [DATA_W-1:0] e);
        notes.push_back('{mcyc + 3, k, e});
    endtask : note
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    // outputs settle three edges after the pins are driven; check at the falling edge
    always @(negedge hclk) begin
        logic [DATA_W-1:0] got;
        while (notes.size() > 0 && notes[0].due == mcyc) begin
            case (notes[0].kind)
                0: got = mem_out;
                1: got = {17'h0, full_n};
                2: got = host_out;
                3: got = {17'h0, host_oe};
                default: got = {17'h0, mem_oe};
            endcase
            `CHK(nm[notes[0].kind], notes[0].exp, got)
            void'(notes.pop_front());
        end
        mcyc++;
    end
    // a hang is cut short well beyond the expected run length
    always @(posedge hclk) begin
        ticks++;
        if (ticks >= 20000) begin
            bad_count++;
            close_out();
        end
    end
    // ****************************************
    // drivers
    // ****************************************
    // one queue cycle on the pins; the reference decides from the count before the edge
    task automatic op(input logic w, input logic r, input logic s, input logic [DATA_W-1:0] d);
        int n;
        @(posedge hclk);
        wr_n <= ~w;
        rd_n <= ~r;
        qrst_n <= ~s;
        host_drv <= d;
        n = fq.size();
        if (s) begin
            fq.delete();
            cur = QUEUE_OUT_RESET;
        end else begin
            if (r && n > 0) begin
                cur = fq.pop_front();
                if (mq.size() < MON_DEPTH) mq.push_back(cur); // pop log keeps words while it has room
            end
            if (w && n < DEPTH) fq.push_back(d);
        end
        note(0, cur);
        note(1, {17'h0, fq.size() != DEPTH});
    endtask : op
    // single ahb-lite word transfer, address phase held until hready
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        // only the bench timeout ends a wait
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        `CHK("hresp", HRESP_OKAY, hresp)
    endtask : ahb
    task automatic status_check();
        repeat (6) op(0, 0, 0, '0);
        ahb(0, STATUS_ADDR, '0);
        sx = '0;
        sx[STAT_COUNT_LSB+:3] = fq.size();
        sx[STAT_FULL_N_BIT] = fq.size() != DEPTH;
        sx[STAT_EMPTY_BIT] = fq.size() == 0;
        sx[STAT_MON_LSB+:2] = mq.size();
        `CHK("status", sx[6:0], rd[6:0])
        `CHK("mon_ready", mq.size() != MON_DEPTH, mon_ready)
    endtask : status_check
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        op(0, 0, 1, '0);
        // random traffic: a filling phase, then a draining phase, with rare queue resets
        for (int i = 0; i < 300; i++) begin
            r1 = $random(seed);
            op(r1[0] | (i < 150 && r1[1]), r1[2] | (i >= 150 && r1[3]), r1[7:4] == 0, r1[25:8]);
        end
        status_check();
        // oldest logged pop comes back through the register port
        ahb(0, MON_ADDR, '0);
        sx = '0;
        if (mq.size() > 0) begin
            sx[DATA_W-1:0] = mq.pop_front();
            sx[MON_VALID_BIT] = 1'b1;
        end
        `CHK("mon", sx, rd)
        // overfill by one, then flush through the register port
        repeat (5) op(1, 0, 0, DATA_W'($random(seed)));
        status_check();
        ahb(1, CTRL_ADDR, 32'h1);
        fq.delete();
        cur = QUEUE_OUT_RESET;
        status_check();
        ahb(0, 32'hc, '0);
        `CHK("unmapped", 32'h0, rd)
        // read latch: transparent while open, holds when closed, queue untouched
        w1 = DATA_W'($random(seed));
        @(posedge hclk);
        a_oe_n <= 1'b0;
        latch_open <= 1'b1;
        mem_drv <= 1'b1;
        mem_word <= w1;
        repeat (5) op(0, 0, 0, '0);
        note(2, w1);
        note(3, 18'h1);
        note(4, 18'h0);
        @(posedge hclk);
        latch_open <= 1'b0;
        mem_word <= ~w1;
        repeat (3) op(0, 0, 0, '0);
        mem_drv <= 1'b0;
        b_oe_n <= 1'b0;
        repeat (3) op(0, 0, 0, '0);
        note(2, w1);
        note(4, 18'h1);
        a_oe_n <= 1'b1;
        repeat (5) op(0, 0, 0, '0);
        note(3, 18'h0);
        repeat (6) op(0, 0, 0, '0);
        // let the last notes fall due before the verdict
        repeat (4) @(posedge hclk);
        close_out();
    end
endmodule : buffered_rw_bus_transceiver_tb
